//--- wdcm_regs.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  windowed watchdog and clock monitor.
  Assumes: included by bare name wherever these names are needed.
*/
`ifndef WDCM_REGS_SVH
`define WDCM_REGS_SVH

// Register byte offsets on the APB
`define WDCM_SVC_OFF     12'h000
`define WDCM_CTRL_OFF    12'h004

// Service register fields
`define WDCM_WIN_HI      7
`define WDCM_WIN_LO      6
`define WDCM_KEY_HI      5
`define WDCM_KEY_LO      1
`define WDCM_CM_BIT      0
`define WDCM_KEY_VAL     5'h0c
`define WDCM_WIN_RST     2'h3
`define WDCM_CM_RST      1'b1

// Control / status register fields
`define WDCM_ISEL_HI     2
`define WDCM_ISEL_LO     0
`define WDCM_PEND_BIT    3
`define WDCM_CFG_BIT     4
`define WDCM_CMERR_BIT   5
`define WDCM_DRV_BIT     6
`define WDCM_PIN_BIT     7
`define WDCM_ISEL_RST    3'h0
`define WDCM_ISEL_MAX    3'h4

// Window limits in idle timer clocks
`define WDCM_LOWER       17'h00800
`define WDCM_UPPER_BASE  17'h02000
`define WDCM_ITMR_BASE   12

// Fault pulse stretch, in instruction cycles (inside 16..32)
`define WDCM_REL_TICKS   6'h18

// Clock monitor reject time: between 200 us (5 kHz) and 100 ms (10 Hz)
`define WDCM_CM_TMO_US   1000
`define WDCM_SYS_MHZ     40

`endif

//--- wdcm_pkg.sv
/*
  Types shared by the watchdog and clock monitor.
  Assumes: compiled before the design module.
*/
package wdcm_pkg;

  // APB request from the master, one bundle
  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_s;

  // Fault pulse sequencer, one-hot
  typedef enum logic [3:0] {
    PLS_OFF  = 4'b0001,
    PLS_PULL = 4'b0010,
    PLS_HOLD = 4'b0100,
    PLS_RISE = 4'b1000
  } pulse_e;

endpackage

//--- watchdog_clock_monitor.sv
/*
  Windowed watchdog with clock-frequency monitor, APB register slave and
  an open-drain fault pin shared with the system reset circuit.
  Assumes: tc_tick pulses once per instruction cycle in sys_clk; halt_mode,
  idle_mode and boot_rom_active are levels from the core; shared_fault_pin_i
  is the pin level after the input threshold; por clears the idle timer.
*/
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "wdcm_regs.svh"

module watchdog_clock_monitor
  import wdcm_pkg::*;
#(
  parameter int CM_TMO_CYC = `WDCM_CM_TMO_US * `WDCM_SYS_MHZ
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire apb_req_s    apb_req,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wd_option_n,
  input  wire logic        tc_tick,
  input  wire logic        halt_mode,
  input  wire logic        idle_mode,
  input  wire logic        boot_rom_active,
  input  wire logic        shared_fault_pin_i,
  output logic             shared_fault_pin_o,
  output logic             shared_fault_pin_oe,
  output logic             idle_timer_pending
);

  localparam int CMW = $clog2(CM_TMO_CYC + 1);

  // Refuse a reject time below 2 or above 4000000 sys_clk cycles (100 ms at 40 MHz)
  if (CM_TMO_CYC < 2 || CM_TMO_CYC > 4000000) begin : g_bad_tmo
    $error("CM_TMO_CYC out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [16:0] upper_lim(input logic [1:0] sel);
    upper_lim = `WDCM_UPPER_BASE << sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]  win_r;
  logic        cm_en_r;
  logic        cfg_done_r;
  logic [16:0] wd_cnt_r;
  logic        low_mask_r;
  logic        boot_d_r;
  logic        halt_d_r;
  logic        idle_d_r;
  logic [16:0] itmr_r;
  logic        itmr_bit_d_r;
  logic [2:0]  isel_r;
  logic        pend_r;
  logic [CMW-1:0] cm_cnt_r;
  logic        cm_hold_r;
  logic [5:0]  cm_rel_r;
  pulse_e      pls_r;
  pulse_e      pls_nxt;
  logic [5:0]  pls_cnt_r;
  logic [31:0] prdata_r;

  logic wd_on;
  logic sleeping;
  logic wr_acc;
  logic svc_wr;
  logic ctl_wr;
  logic key_ok;
  logic all_ok;
  logic early;
  logic sw_err;
  logic late;
  logic wd_err;
  logic hw_svc;
  logic cm_slow;
  logic fault_out_n;
  logic itmr_bit;
  logic svc_open;

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode; zero wait states, unmapped addresses answer an error

  assign pready  = apb_req.psel & apb_req.penable;
  assign pslverr = pready & ~(hit(apb_req.paddr, `WDCM_SVC_OFF) | hit(apb_req.paddr, `WDCM_CTRL_OFF));
  assign wr_acc  = pready & apb_req.pwrite & ~pslverr;
  assign svc_wr  = wr_acc & hit(apb_req.paddr, `WDCM_SVC_OFF);
  assign ctl_wr  = wr_acc & hit(apb_req.paddr, `WDCM_CTRL_OFF);
  assign prdata  = prdata_r;

  // Field checks on the written value
  assign key_ok = apb_req.pwdata[`WDCM_KEY_HI:`WDCM_KEY_LO] == `WDCM_KEY_VAL;
  assign all_ok = key_ok
                & (apb_req.pwdata[`WDCM_WIN_HI:`WDCM_WIN_LO] == win_r)
                & (apb_req.pwdata[`WDCM_CM_BIT] == cm_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog service and error detection

  assign wd_on    = ~wd_option_n;
  assign sleeping = halt_mode | idle_mode;
  // Early service is legal for the first service and in boot ROM
  assign early    = cfg_done_r & ~low_mask_r & (wd_cnt_r < `WDCM_LOWER);
  // A write while either source pulls the pin, or while asleep, never reaches the checks
  assign svc_open = (pls_r == PLS_OFF) & ~cm_hold_r & ~sleeping;
  assign sw_err   = svc_wr & svc_open
                  & (cfg_done_r ? (~all_ok | early) : ~key_ok);
  assign late     = ~sleeping & (pls_r == PLS_OFF) & (wd_cnt_r >= upper_lim(win_r));
  assign wd_err   = wd_on & (sw_err | late);
  // Boot ROM entry and exit, halt exit and idle exit restart the window
  assign hw_svc   = (boot_rom_active ^ boot_d_r)
                  | (halt_d_r & ~halt_mode)
                  | (idle_d_r & ~idle_mode);

  // Configuration fixed by the first keyed write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      win_r      <= `WDCM_WIN_RST;
      cm_en_r    <= `WDCM_CM_RST;
      cfg_done_r <= 1'b0;
    end
    else if (svc_wr && svc_open && !cfg_done_r && key_ok)
    begin
      win_r      <= apb_req.pwdata[`WDCM_WIN_HI:`WDCM_WIN_LO];
      cm_en_r    <= apb_req.pwdata[`WDCM_CM_BIT];
      cfg_done_r <= 1'b1;
    end
  end

  // Core edge history for boot ROM, halt and idle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      boot_d_r <= 1'b0;
      halt_d_r <= 1'b0;
      idle_d_r <= 1'b0;
    end
    else
    begin
      boot_d_r <= boot_rom_active;
      halt_d_r <= halt_mode;
      idle_d_r <= idle_mode;
    end
  end

  // Lower limit masked while running from boot ROM
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      low_mask_r <= 1'b0;
    else
      low_mask_r <= boot_rom_active;
  end

  // Window counter in idle timer clocks; frozen in halt and idle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wd_cnt_r <= '0;
    else if (pls_r != PLS_OFF || hw_svc || (svc_wr && svc_open && !sw_err))
      wd_cnt_r <= '0;
    else if (tc_tick && !sleeping && wd_cnt_r != upper_lim(win_r))
      wd_cnt_r <= wd_cnt_r + 17'h00001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault pulse: pull low, wait for the pin to sink, stretch, wait for rise

  always_comb
  begin
    pls_nxt = pls_r;
    case (pls_r)
      PLS_OFF:
        if (wd_err)
          pls_nxt = PLS_PULL;
      PLS_PULL:
        if (!shared_fault_pin_i)
          pls_nxt = PLS_HOLD;
      PLS_HOLD:
        if (tc_tick && pls_cnt_r == `WDCM_REL_TICKS - 6'h01)
          pls_nxt = PLS_RISE;
      PLS_RISE:
        if (shared_fault_pin_i)
          pls_nxt = PLS_OFF;
      default:
        pls_nxt = PLS_OFF;
    endcase
  end

  // State register; reset inhibits any pulse
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pls_r <= PLS_OFF;
    else
      pls_r <= pls_nxt;
  end

  // Stretch counter, in instruction cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst || pls_r != PLS_HOLD)
      pls_cnt_r <= '0;
    else if (tc_tick)
      pls_cnt_r <= pls_cnt_r + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock monitor: sys_clk cycles since the last instruction cycle.
  // Keeps running in halt and idle, so a stopped clock shows as an error.

  assign cm_slow = wd_on & cm_en_r & (cm_cnt_r >= CMW'(CM_TMO_CYC));

  always_ff @(posedge sys_clk)
  begin
    if (rst || tc_tick)
      cm_cnt_r <= '0;
    else if (cm_cnt_r != CMW'(CM_TMO_CYC))
      cm_cnt_r <= cm_cnt_r + CMW'(1);
  end

  // Hold pin low while slow; release after a run of good cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cm_hold_r <= 1'b0;
      cm_rel_r  <= '0;
    end
    else if (cm_slow)
    begin
      cm_hold_r <= 1'b1;
      cm_rel_r  <= '0;
    end
    else if (cm_hold_r && tc_tick)
    begin
      cm_rel_r <= cm_rel_r + 6'h01;
      if (cm_rel_r == `WDCM_REL_TICKS - 6'h01)
        cm_hold_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared open-drain pin; either source alone pulls it low

  assign fault_out_n         = ~((pls_r == PLS_PULL) | (pls_r == PLS_HOLD) | cm_hold_r);
  assign shared_fault_pin_o  = 1'b0;
  assign shared_fault_pin_oe = wd_on & ~fault_out_n;

  ////////////////////////////////////////////////////////////////////////////
  // Idle timer: cleared only at power-on, never by rst

  assign itmr_bit = itmr_r[`WDCM_ITMR_BASE + 32'(isel_r)];

  always_ff @(posedge sys_clk)
  begin
    if (por)
    begin
      itmr_r       <= '0;
      itmr_bit_d_r <= 1'b0;
    end
    else
    begin
      if (tc_tick)
        itmr_r <= itmr_r + 17'h00001;
      itmr_bit_d_r <= itmr_bit;
    end
  end

  // Interval select; values above 64k are refused
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      isel_r <= `WDCM_ISEL_RST;
    else if (ctl_wr && apb_req.pwdata[`WDCM_ISEL_HI:`WDCM_ISEL_LO] <= `WDCM_ISEL_MAX)
      isel_r <= apb_req.pwdata[`WDCM_ISEL_HI:`WDCM_ISEL_LO];
  end

  // Sticky pending; a toggle in the clearing cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (por)
      pend_r <= 1'b0;
    else if (itmr_bit != itmr_bit_d_r)
      pend_r <= 1'b1;
    else if (ctl_wr && apb_req.pwdata[`WDCM_PEND_BIT])
      pend_r <= 1'b0;
  end

  assign idle_timer_pending = pend_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase so it stands through access

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prdata_r <= '0;
    else if (apb_req.psel && !apb_req.penable)
    begin
      prdata_r <= '0;
      if (hit(apb_req.paddr, `WDCM_SVC_OFF))
      begin
        prdata_r[`WDCM_WIN_HI:`WDCM_WIN_LO] <= win_r;
        prdata_r[`WDCM_CM_BIT]              <= cm_en_r;
      end
      else if (hit(apb_req.paddr, `WDCM_CTRL_OFF))
      begin
        prdata_r[`WDCM_ISEL_HI:`WDCM_ISEL_LO] <= isel_r;
        prdata_r[`WDCM_PEND_BIT]              <= pend_r;
        prdata_r[`WDCM_CFG_BIT]               <= cfg_done_r;
        prdata_r[`WDCM_CMERR_BIT]             <= cm_hold_r;
        prdata_r[`WDCM_DRV_BIT]               <= ~fault_out_n;
        prdata_r[`WDCM_PIN_BIT]               <= shared_fault_pin_i;
      end
    end
  end

endmodule // watchdog_clock_monitor

//--- wdcm_props.sv
/*
  Port-level checks of the watchdog and clock monitor.
  Assumes: bound into watchdog_clock_monitor; tc_tick is one pulse per tick.
*/
`timescale 1ns/1ps
module wdcm_props
  import wdcm_pkg::*;
#(
  parameter int CM_TMO_CYC = 64
)(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        por,
  input wire apb_req_s    apb_req,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wd_option_n,
  input wire logic        tc_tick,
  input wire logic        shared_fault_pin_i,
  input wire logic        shared_fault_pin_o,
  input wire logic        shared_fault_pin_oe,
  input wire logic        idle_timer_pending
);
  logic [6:0] stretch_r;
  logic       acc;
  ////////////////////////////////////////////////////////////////
  // Ticks with pin pulled and seen low; bounds the stretch both ways
  always_ff @(posedge sys_clk)
  begin
    if (rst || !shared_fault_pin_oe)
      stretch_r <= 7'h00;
    else if (tc_tick && !shared_fault_pin_i)
      stretch_r <= stretch_r + 7'h01;
  end
  assign acc = apb_req.psel && apb_req.penable;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Zero wait states; only the two offsets answer without error
  a_access_resp: assert property (acc |-> pready && (pslverr == !(apb_req.paddr inside {12'h000, 12'h004})))
    else $error("access answer wrong");
  a_option_gate: assert property (wd_option_n |-> !shared_fault_pin_oe)
    else $error("pin pulled while disabled");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !shared_fault_pin_oe && prdata == 32'h0)
    else $error("reset not quiet");
  a_key_hidden: assert property (acc && !apb_req.pwrite && apb_req.paddr == 12'h000 |-> prdata[5:1] == 5'h00)
    else $error("key visible");
  a_drive_level: assert property (shared_fault_pin_o == 1'b0)
    else $error("pin driven high");
  a_stretch_min: assert property ($fell(shared_fault_pin_oe) |-> stretch_r >= 7'd16)
    else $error("pulse too short");
  a_stretch_max: assert property (shared_fault_pin_oe |-> stretch_r <= 7'd34)
    else $error("pulse too long");
  a_pend_sticky: assert property (disable iff (por) idle_timer_pending
    && !(acc && apb_req.pwrite && apb_req.paddr == 12'h004 && apb_req.pwdata[3]) |=> idle_timer_pending)
    else $error("pending lost");
  a_quiet_start: assert property ($fell(rst) |-> !shared_fault_pin_oe [*8])
    else $error("early fault");
  c_fault: cover property ($rose(shared_fault_pin_oe));
  c_pend: cover property ($rose(idle_timer_pending));
  c_slverr: cover property (acc && pslverr);
endmodule // wdcm_props

//--- wdcm_reset_partner.sv
/*
  Reset circuit at the fault pin: weak pull-up, slow fall seen after LAG edges.
  Assumes: the design only ever pulls the pin low.
*/
`timescale 1ns/1ps
module wdcm_reset_partner #(
  parameter int LAG = 2
)(
  input wire logic sys_clk,
  input wire logic drive_o,
  input wire logic drive_oe,
  output logic     pin_i
);
  logic [7:0] lag_r = 8'hff;
  ////////////////////////////////////////////////////////////////
  // Pull-up wins when released; the threshold is crossed late on purpose
  always_ff @(posedge sys_clk)
    lag_r <= {lag_r[6:0], drive_oe ? drive_o : 1'b1};
  assign pin_i = lag_r[LAG-1];
endmodule // wdcm_reset_partner

//--- tb_watchdog_clock_monitor.sv
/*
  Self-checking bench: APB tasks and watchdog, monitor and timer scenarios.
  Assumes: ticks every cycle except where a scenario stalls them.
*/
`timescale 1ns/1ps
module tb_watchdog_clock_monitor;
  import wdcm_pkg::*;
  localparam int CM_TMO_CYC = 64;
  logic        sys_clk, rst, por, wd_option_n, tc_tick, halt_mode, idle_mode, boot_rom_active;
  logic        pready, pslverr, pin_i, pin_o, pin_oe, idle_timer_pending, slv;
  logic [31:0] prdata, rd;
  apb_req_s    apb_req;
  int          err_total, total_checks, n, i;
  logic [7:0]  bad [3] = '{8'h18, 8'h59, 8'h50};
  watchdog_clock_monitor #(.CM_TMO_CYC(CM_TMO_CYC)) dut_u (.sys_clk, .rst, .por, .apb_req, .prdata,
    .pready, .pslverr, .wd_option_n, .tc_tick, .halt_mode, .idle_mode, .boot_rom_active,
    .shared_fault_pin_i(pin_i), .shared_fault_pin_o(pin_o), .shared_fault_pin_oe(pin_oe),
    .idle_timer_pending);
  wdcm_reset_partner partner_u (.sys_clk, .drive_o(pin_o), .drive_oe(pin_oe), .pin_i);
  ////////////////////////////////////////////////////////////////
  // Compare, verdict, bus cycle and bounded waits
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // Request held until pready is seen at an edge; extra edge avoids re-driving
  // No own limit: only the bench watchdog ends a stuck access
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    apb_req <= '{a, w, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_on(input logic pin, input logic v, input int lim);
    n = 0;
    while ((pin ? pin_i : pin_oe) !== v && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    // A wait that runs out is a mismatch in its own right
    if ((pin ? pin_i : pin_oe) !== v)
    begin
      err_total++;
      $display("[ERR] %0t ns: wait ran out", $time);
    end
  endtask
  task automatic rise(input int lim);
    wait_on(1'b0, 1'b1, lim);
    chk(pin_oe, 1'b1);
  endtask
  // Stretch counted from the pin seen low; after a watchdog pulse the window restarts at pin high
  task automatic settle();
    wait_on(1'b1, 1'b0, 8);
    wait_on(1'b0, 1'b0, 60);
    chk(n >= 16 && n <= 33, 1'b1);
    wait_on(1'b1, 1'b1, 8);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog sized well past the longest path through the scenarios
  initial
  begin
    wt(100000);
    err_total++;
    finish_test();
  end
  initial
  begin
    {rst, por, wd_option_n, tc_tick, halt_mode, idle_mode, boot_rom_active} = 7'b1100000;
    apb_req = '0;
    err_total = 0;
    total_checks = 0;
    wt(10);
    rst <= 1'b0;
    por <= 1'b0;
    rise(CM_TMO_CYC + 10);
    tc_tick <= 1'b1;
    settle();
    xfer(12'h000, 1'b0, 0);
    chk(rd, 32'hc1);
    xfer(12'h008, 1'b0, 0);
    chk(slv, 1'b1);
    xfer(12'h000, 1'b1, 32'h58);
    wt(20);
    chk(pin_oe, 1'b0);
    xfer(12'h000, 1'b0, 0);
    chk(rd, 32'h40);
    xfer(12'h000, 1'b1, 32'h58);
    rise(4);
    settle();
    for (i = 0; i < 3; i++)
    begin
      wt(2100);
      xfer(12'h000, 1'b1, {24'h0, bad[i]});
      rise(4);
      settle();
    end
    wt(2100);
    xfer(12'h000, 1'b1, 32'h58);
    wt(15000);
    chk(pin_oe, 1'b0);
    rise(1500);
    chk(n >= 1375 && n <= 1392, 1'b1);
    settle();
    wt(2100);
    xfer(12'h000, 1'b1, 32'h58);
    wt(15000);
    halt_mode <= 1'b1;
    wt(2000);
    halt_mode <= 1'b0;
    wt(2100);
    chk(pin_oe, 1'b0);
    xfer(12'h000, 1'b1, 32'h58);
    wt(4);
    chk(pin_oe, 1'b0);
    wt(15000);
    idle_mode <= 1'b1;
    wt(10);
    idle_mode <= 1'b0;
    wt(3000);
    chk(pin_oe, 1'b0);
    boot_rom_active <= 1'b1;
    wt(5);
    xfer(12'h000, 1'b1, 32'h58);
    wt(4);
    chk(pin_oe, 1'b0);
    boot_rom_active <= 1'b0;
    wt(5);
    xfer(12'h000, 1'b1, 32'h58);
    rise(4);
    settle();
    xfer(12'h004, 1'b1, 32'h8);
    wt(4100);
    xfer(12'h004, 1'b0, 0);
    chk(rd[3], 1'b1);
    rst <= 1'b1;
    wt(10);
    rst <= 1'b0;
    chk(idle_timer_pending, 1'b1);
    xfer(12'h004, 1'b1, 32'h8);
    chk(idle_timer_pending, 1'b0);
    halt_mode <= 1'b1;
    tc_tick <= 1'b0;
    rise(CM_TMO_CYC + 10);
    halt_mode <= 1'b0;
    tc_tick <= 1'b1;
    settle();
    wd_option_n <= 1'b1;
    tc_tick <= 1'b0;
    wt(CM_TMO_CYC + 20);
    chk(pin_oe, 1'b0);
    finish_test();
  end
endmodule // tb_watchdog_clock_monitor

bind watchdog_clock_monitor wdcm_props #(.CM_TMO_CYC(CM_TMO_CYC)) props_u (.sys_clk, .rst, .por,
  .apb_req, .prdata, .pready, .pslverr, .wd_option_n, .tc_tick, .shared_fault_pin_i,
  .shared_fault_pin_o, .shared_fault_pin_oe, .idle_timer_pending);
